// ---- pointer_interpreter.sv ----
// receive pointer interpreter with wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "pi_params.svh"
module pointer_interpreter (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pointer words from the frame aligner
   input wire logic word_valid_i,
   input wire logic word_first_i,
   input wire logic [15:0] word_i,
   input wire logic frame_end_i,
   // interrupts
   output logic irq_out_first_o,
   output logic irq_out_second_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [3:0] pop10(input logic [9:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int k = 0; k < 10; k++) begin
         c = c + {3'h0, v[k]};
      end
      return c;
   endfunction : pop10

   function automatic logic maj3(input logic [3:0] n, input logic [3:0] p);
      logic [3:0] m;
      m = ~(n ^ p);
      return ({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]}) >= `MAJ3;
   endfunction : maj3

   function automatic logic ss_ok(input logic [15:0] w, input logic sdh);
      return !sdh || (w[`F_SS] == `SS_SDH);
   endfunction : ss_ok

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [15:0] prim_q, prim_d;
   logic seen_q, seen_d, ci_bad_q, ci_bad_d;
   pi_pkg::pi_state_t st_q, st_d;
   logic [9:0] cur_q, cur_d, cand_q, cand_d;
   logic [1:0] same_q, same_d, ais_q, ais_d, hold_q, hold_d;
   logic [3:0] inv_q, inv_d;
   logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
   logic pa_stat_q, pa_stat_d, pl_stat_q, pl_stat_d;
   logic pa_pend_q, pa_pend_d, pl_pend_q, pl_pend_d;
   logic ack_q, ack_d, irq1_q, irq1_d, irq2_q, irq2_d;
   logic [31:0] dat_q, dat_d;

   pi_pkg::pi_kind_t kind;
   logic [9:0] val, diff;
   logic sdh, eval, inc, dec, adj_ok, valid, take, rd_stat;

   assign sdh = ctrl_q[`C_SDH];
   assign eval = frame_end_i;
   assign val = prim_q[`F_VAL];
   assign diff = val ^ cur_q;

   // ----------------------------------------
   // classification of the primary pointer
   // ----------------------------------------
   always_comb begin
      if (sdh) begin
         inc = pop10(diff & `I_MASK) >= `SDH_INV && pop10(diff & `D_MASK) <= `SDH_OTHER;
         dec = pop10(diff & `D_MASK) >= `SDH_INV && pop10(diff & `I_MASK) <= `SDH_OTHER;
      end else begin
         inc = pop10(~(val ^ (cur_q ^ `I_MASK))) >= `SON_MATCH;
         dec = pop10(~(val ^ (cur_q ^ `D_MASK))) >= `SON_MATCH;
      end
      kind = pi_pkg::K_BAD;
      if (!seen_q) begin
         kind = pi_pkg::K_BAD;
      end else if (prim_q == `AIS_WORD) begin
         kind = pi_pkg::K_AIS;
      end else if (!ss_ok(prim_q, sdh)) begin
         kind = pi_pkg::K_BAD;
      end else if (maj3(prim_q[`F_NF], `NF_NDF) && val <= `PTR_MAX) begin
         kind = pi_pkg::K_NDF;
      end else if (maj3(prim_q[`F_NF], `NF_NORM)) begin
         if (st_q == pi_pkg::ST_NORM && val == cur_q) begin
            kind = pi_pkg::K_NORM;
         end else if (st_q == pi_pkg::ST_NORM && inc) begin
            kind = pi_pkg::K_INC;
         end else if (st_q == pi_pkg::ST_NORM && dec) begin
            kind = pi_pkg::K_DEC;
         end else if (val <= `PTR_MAX) begin
            kind = pi_pkg::K_NORM;
         end
      end
   end

   // ----------------------------------------
   // frame capture and pointer state machine
   // ----------------------------------------
   always_comb begin
      prim_d = prim_q;
      seen_d = seen_q;
      ci_bad_d = ci_bad_q;
      st_d = st_q;
      cur_d = cur_q;
      cand_d = cand_q;
      same_d = same_q;
      ais_d = ais_q;
      hold_d = hold_q;
      inv_d = inv_q;
      adj_ok = (kind == pi_pkg::K_INC || kind == pi_pkg::K_DEC) && hold_q == 2'h0;
      valid = 1'b0;
      if (st_q == pi_pkg::ST_AIS) begin
         valid = kind == pi_pkg::K_AIS;
      end else if (st_q == pi_pkg::ST_NORM) begin
         valid = (kind == pi_pkg::K_NORM && val == cur_q) || kind == pi_pkg::K_NDF || adj_ok;
      end
      valid = valid && !ci_bad_q;
      if (eval) begin
         seen_d = 1'b0;
         ci_bad_d = 1'b0;
         hold_d = (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
         ais_d = (kind == pi_pkg::K_AIS) ? ((ais_q == `RUN3 + 2'h1) ? ais_q : ais_q + 2'h1) : 2'h0;
         if (kind == pi_pkg::K_NORM) begin
            cand_d = val;
            same_d = (cand_q == val && same_q != `RUN3 + 2'h1) ? same_q + 2'h1 : ((cand_q == val) ? same_q : 2'h1);
         end else begin
            same_d = 2'h0;
         end
         inv_d = valid ? 4'h0 : ((inv_q == `LOP_RUN + 4'h1) ? inv_q : inv_q + 4'h1);
         if (kind == pi_pkg::K_NDF && st_q != pi_pkg::ST_LOP) begin
            st_d = pi_pkg::ST_NORM;
            cur_d = val;
            hold_d = `HOLD_FR;
         end else if (kind == pi_pkg::K_NORM && cand_q == val && same_q == `RUN3) begin
            st_d = pi_pkg::ST_NORM;
            cur_d = val;
         end else if (kind == pi_pkg::K_AIS && ais_q == `RUN3 && st_q != pi_pkg::ST_AIS) begin
            st_d = pi_pkg::ST_AIS;
         end else if (adj_ok) begin
            hold_d = `HOLD_FR;
            if (kind == pi_pkg::K_INC) begin
               cur_d = (cur_q == `PTR_MAX) ? 10'h000 : cur_q + 10'h001;
            end else begin
               cur_d = (cur_q == 10'h000) ? `PTR_MAX : cur_q - 10'h001;
            end
         end else if (!valid && inv_q >= `LOP_RUN && st_q != pi_pkg::ST_LOP) begin
            st_d = pi_pkg::ST_LOP;
         end
         // the count may saturate while another transition wins, so test with >=
         // loss state restarts the count, also on the frame that leaves it
         if (st_q == pi_pkg::ST_LOP || st_d == pi_pkg::ST_LOP) begin
            inv_d = 4'h0;
         end
      end
      if (word_valid_i) begin
         if (word_first_i) begin
            prim_d = word_i;
            seen_d = 1'b1;
         end else if (!((maj3(word_i[`F_NF], `NF_NDF) && word_i[`F_VAL] == `CI_VAL
                        && ss_ok(word_i, sdh)) || word_i == `AIS_WORD)) begin
            ci_bad_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prim_q <= 16'h0000;
         seen_q <= 1'b0;
         ci_bad_q <= 1'b0;
         st_q <= pi_pkg::ST_LOP;
         cur_q <= 10'h000;
         cand_q <= 10'h000;
         same_q <= 2'h0;
         ais_q <= 2'h0;
         hold_q <= 2'h0;
         inv_q <= 4'h0;
      end else begin
         prim_q <= prim_d;
         seen_q <= seen_d;
         ci_bad_q <= ci_bad_d;
         st_q <= st_d;
         cur_q <= cur_d;
         cand_q <= cand_d;
         same_q <= same_d;
         ais_q <= ais_d;
         hold_q <= hold_d;
         inv_q <= inv_d;
      end
   end

   // ----------------------------------------
   // register slave, alarms and interrupts
   // ----------------------------------------
   // a status read returns the latched value, then reloads the live level
   always_comb begin
      ctrl_d = ctrl_q;
      dat_d = dat_q;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      take = ack_d;
      rd_stat = take && !wb_we_i && wb_adr_i == `A_STAT;
      if (take && !wb_we_i) begin
         if (wb_adr_i == `A_CTRL) begin
            dat_d = {27'h0, ctrl_q};
         end else if (wb_adr_i == `A_STAT) begin
            dat_d = {26'h0, st_q, pl_pend_q, pa_pend_q, pl_stat_q, pa_stat_q};
         end else if (wb_adr_i == `A_PTR) begin
            dat_d = {22'h0, cur_q};
         end else begin
            dat_d = 32'h0000_0000;
         end
      end
      if (take && wb_we_i && wb_adr_i == `A_CTRL && wb_sel_i[0]) begin
         ctrl_d = wb_dat_i[`CTRL_W-1:0];
      end
      // set wins over the clear of a read in the same cycle
      pa_stat_d = rd_stat ? (st_q == pi_pkg::ST_AIS) : pa_stat_q;
      pl_stat_d = rd_stat ? (st_q == pi_pkg::ST_LOP) : pl_stat_q;
      pa_pend_d = rd_stat ? 1'b0 : pa_pend_q;
      pl_pend_d = rd_stat ? 1'b0 : pl_pend_q;
      if ((st_q == pi_pkg::ST_AIS) != (st_d == pi_pkg::ST_AIS)) begin
         pa_stat_d = 1'b1;
         pa_pend_d = 1'b1;
      end
      if ((st_q == pi_pkg::ST_LOP) != (st_d == pi_pkg::ST_LOP)) begin
         pl_stat_d = 1'b1;
         pl_pend_d = 1'b1;
      end
      irq1_d = (pa_pend_q && ctrl_q[`C_PA1]) || (pl_pend_q && ctrl_q[`C_PL1]);
      irq2_d = (pa_pend_q && ctrl_q[`C_PA2]) || (pl_pend_q && ctrl_q[`C_PL2]);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= '0;
         dat_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         pa_stat_q <= 1'b0;
         pl_stat_q <= 1'b0;
         pa_pend_q <= 1'b0;
         pl_pend_q <= 1'b0;
         irq1_q <= 1'b0;
         irq2_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         dat_q <= dat_d;
         ack_q <= ack_d;
         pa_stat_q <= pa_stat_d;
         pl_stat_q <= pl_stat_d;
         pa_pend_q <= pa_pend_d;
         pl_pend_q <= pl_pend_d;
         irq1_q <= irq1_d;
         irq2_q <= irq2_d;
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign irq_out_first_o = irq1_q;
   assign irq_out_second_o = irq2_q;

   // ----------------------------------------
   // checks: state machine
   // ----------------------------------------
   // checks look at internal terms so that a wrong rank in the kind chain shows up early
   a_ais_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && kind == pi_pkg::K_AIS && ais_q == `RUN3 && st_q != pi_pkg::ST_AIS
      |=> st_q == pi_pkg::ST_AIS) else $error("alarm state not entered");
   a_lop_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && !valid && inv_q >= `LOP_RUN && st_q != pi_pkg::ST_LOP && kind != pi_pkg::K_AIS
      && kind != pi_pkg::K_NORM && kind != pi_pkg::K_NDF
      |=> st_q == pi_pkg::ST_LOP) else $error("loss state not entered");
   a_ndf_adopt: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && kind == pi_pkg::K_NDF && st_q != pi_pkg::ST_LOP
      |=> st_q == pi_pkg::ST_NORM && cur_q == $past(val) && hold_q == `HOLD_FR)
      else $error("new data flag not adopted");
   a_norm_three: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && kind == pi_pkg::K_NORM && cand_q == val && same_q == `RUN3
      |=> st_q == pi_pkg::ST_NORM && cur_q == $past(val)) else $error("three equal pointers ignored");
   a_ais_word: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && kind == pi_pkg::K_AIS && st_q == pi_pkg::ST_AIS
      |=> st_q == pi_pkg::ST_AIS && inv_q == 4'h0) else $error("alarm pointer not valid in alarm");
   a_ndf_lop: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && kind == pi_pkg::K_NDF && st_q == pi_pkg::ST_LOP
      |=> st_q == pi_pkg::ST_LOP) else $error("new data flag left loss state");
   a_three_states: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == pi_pkg::ST_NORM || st_q == pi_pkg::ST_LOP || st_q == pi_pkg::ST_AIS)
      else $error("state outside the three states");

   // ----------------------------------------
   // checks: classification
   // ----------------------------------------
   a_norm_range: assert property (@(posedge clk_i) disable iff (rst_i)
      kind == pi_pkg::K_NORM |-> val <= `PTR_MAX) else $error("normal pointer out of range");
   a_ndf_range: assert property (@(posedge clk_i) disable iff (rst_i)
      kind == pi_pkg::K_NDF |-> val <= `PTR_MAX && maj3(prim_q[`F_NF], `NF_NDF))
      else $error("new data flag misread");
   a_size_sdh: assert property (@(posedge clk_i) disable iff (rst_i)
      sdh && kind != pi_pkg::K_AIS && kind != pi_pkg::K_BAD |-> prim_q[`F_SS] == `SS_SDH)
      else $error("size bits not checked");

   // ----------------------------------------
   // checks: justification
   // ----------------------------------------
   a_inc_step: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && adj_ok && kind == pi_pkg::K_INC && cur_q != `PTR_MAX
      |=> cur_q == $past(cur_q) + 10'h001) else $error("increment step wrong");
   a_dec_step: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && adj_ok && kind == pi_pkg::K_DEC && cur_q != 10'h000
      |=> cur_q == $past(cur_q) - 10'h001) else $error("decrement step wrong");
   a_inc_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && adj_ok && kind == pi_pkg::K_INC && cur_q == `PTR_MAX
      |=> cur_q == 10'h000) else $error("increment wrap wrong");
   a_dec_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && adj_ok && kind == pi_pkg::K_DEC && cur_q == 10'h000
      |=> cur_q == `PTR_MAX) else $error("decrement wrap wrong");
   a_adj_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && hold_q != 2'h0 && (kind == pi_pkg::K_INC || kind == pi_pkg::K_DEC)
      |=> cur_q == $past(cur_q)) else $error("adjustment inside hold-off");
   a_sdh_both: assert property (@(posedge clk_i) disable iff (rst_i)
      eval && sdh && pop10(diff & `I_MASK) >= `SDH_INV && pop10(diff & `D_MASK) >= `SDH_INV
      && kind != pi_pkg::K_NDF && kind != pi_pkg::K_NORM
      |=> cur_q == $past(cur_q)) else $error("adjusted on ambiguous pointer");

   // ----------------------------------------
   // checks: alarms, interrupts and bus
   // ----------------------------------------
   a_pa_event: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st_q == pi_pkg::ST_AIS) |-> pa_pend_q && pa_stat_q) else $error("alarm event not flagged");
   a_pl_event: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st_q == pi_pkg::ST_LOP) |-> pl_pend_q && pl_stat_q)
      else $error("loss event not flagged");
   a_pa_irq1: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(pa_pend_q) && ctrl_q[`C_PA1]
      |=> irq1_q) else $error("alarm event not routed to first irq");
   a_pa_irq2: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(pa_pend_q) && ctrl_q[`C_PA2]
      |=> irq2_q) else $error("alarm event not routed to second irq");
   a_pl_irq1: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(pl_pend_q) && ctrl_q[`C_PL1]
      |=> irq1_q) else $error("loss event not routed to first irq");
   a_pl_irq2: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(pl_pend_q) && ctrl_q[`C_PL2]
      |=> irq2_q) else $error("loss event not routed to second irq");
   // a read only clears pending when no alarm change falls in the same cycle
   a_pend_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_stat && ((st_q == pi_pkg::ST_AIS) == (st_d == pi_pkg::ST_AIS))
      |=> !pa_pend_q) else $error("alarm pending not cleared by read");
   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule : pointer_interpreter
`default_nettype wire

// ---- pi_params.svh ----
// constants for the receive pointer interpreter
`ifndef PI_PARAMS_SVH
`define PI_PARAMS_SVH
`define F_NF 15:12
`define F_SS 11:10
`define F_VAL 9:0
`define PTR_MAX 10'h30E
`define NF_NORM 4'h6
`define NF_NDF 4'h9
`define AIS_WORD 16'hFFFF
`define CI_VAL 10'h3FF
`define SS_SDH 2'h2
`define I_MASK 10'h2AA
`define D_MASK 10'h155
`define MAJ3 3'h3
`define SON_MATCH 4'h8
`define SDH_INV 4'h3
`define SDH_OTHER 4'h2
`define HOLD_FR 2'h3
`define RUN3 2'h2
`define LOP_RUN 4'h7
`define A_CTRL 4'h0
`define A_STAT 4'h4
`define A_PTR 4'h8
`define C_SDH 0
`define C_PA1 1
`define C_PA2 2
`define C_PL1 3
`define C_PL2 4
`define CTRL_W 5
`endif

// ---- pi_pkg.sv ----
// types shared by the pointer interpreter
package pi_pkg;
   typedef enum logic [1:0] {ST_NORM, ST_LOP, ST_AIS} pi_state_t;
   typedef enum logic [2:0] {K_BAD, K_NORM, K_NDF, K_AIS, K_INC, K_DEC} pi_kind_t;
endpackage : pi_pkg

// ---- pi_far_tx.sv ----
// far-end transmitter model presenting framed pointer words
`timescale 1ns/1ns
`default_nettype none
module pi_far_tx (
   // clock
   input wire logic clk_i,
   // pointer words toward the interpreter
   output logic word_valid_o,
   output logic word_first_o,
   output logic [15:0] word_o,
   output logic frame_end_o
);
   initial begin
      word_valid_o = 1'h0;
      word_first_o = 1'h0;
      word_o = 16'h0000;
      frame_end_o = 1'h0;
   end
   // ----------------------------------------
   // one frame: primary, concatenation words, end strobe
   // ----------------------------------------
   task automatic send(input logic [15:0] prim, input int n_ci, input logic [15:0] ci);
      @(posedge clk_i);
      word_valid_o <= 1'h1;
      word_first_o <= 1'h1;
      word_o <= prim;
      for (int i = 0; i < n_ci; i++) begin
         @(posedge clk_i);
         word_first_o <= 1'h0;
         word_o <= ci;
      end
      @(posedge clk_i);
      word_valid_o <= 1'h0;
      word_first_o <= 1'h0;
      // idle line shows no stale word, so a late sample cannot pass by luck
      word_o <= ~word_o;
      frame_end_o <= 1'h1;
      @(posedge clk_i);
      frame_end_o <= 1'h0;
   endtask : send
endmodule : pi_far_tx
`default_nettype wire

// ---- tb.sv ----
// self-checking bench: pointer interpreter against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic word_valid_i;
   logic word_first_i;
   logic [15:0] word_i;
   logic frame_end_i;
   logic irq_a;
   logic irq_b;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [15:0] lfsr = 16'h0029;
   logic [1:0] mst = 2'h1;
   logic [9:0] mptr = 10'h000;
   logic [9:0] runv = 10'h000;
   logic [3:0] mstat = 4'h0;
   logic [4:0] mctrl = 5'h00;
   int hold = 0;
   int run = 0;
   int ais = 0;
   int bad = 0;
   logic [31:0] rd;
   pointer_interpreter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .word_valid_i(word_valid_i), .word_first_i(word_first_i), .word_i(word_i),
      .frame_end_i(frame_end_i), .irq_out_first_o(irq_a), .irq_out_second_o(irq_b));
   pi_far_tx tx (.clk_i(clk_i), .word_valid_o(word_valid_i), .word_first_o(word_first_i),
      .word_o(word_i), .frame_end_o(frame_end_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic test_done;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (k >= 50) n_mismatch++;
   endtask : bus
   // ----------------------------------------
   // reference model, evaluated once per frame
   // ----------------------------------------
   task automatic model(input logic [15:0] p);
      logic [9:0] v;
      logic [9:0] x;
      logic [1:0] old;
      logic nf, nrm, ndf, inc, dec, good, op;
      v = p[9:0];
      x = v ^ mptr;
      old = mst;
      good = 1'h0;
      op = 1'h0;
      nf = $countones(p[15:12] ~^ 4'h6) >= 3;
      ndf = $countones(p[15:12] ~^ 4'h9) >= 3 && v <= 10'h30E;
      if (mctrl[0] && p[11:10] != 2'h2) begin
         nf = 1'h0;
         ndf = 1'h0;
      end
      if (mctrl[0]) begin
         inc = $countones(x & 10'h2AA) >= 3 && $countones(x & 10'h155) <= 2;
         dec = $countones(x & 10'h155) >= 3 && $countones(x & 10'h2AA) <= 2;
      end else begin
         inc = $countones(x ~^ 10'h2AA) >= 8;
         dec = $countones(x ~^ 10'h155) >= 8;
      end
      inc = inc && nf && old == 2'h0 && x != 10'h000;
      dec = dec && !inc && nf && old == 2'h0 && x != 10'h000;
      nrm = nf && v <= 10'h30E && !inc && !dec;
      run = nrm ? ((v == runv) ? run + 1 : 1) : 0;
      runv = v;
      ais = (p == 16'hFFFF) ? ais + 1 : 0;
      if (nrm && mst == 2'h0 && x == 10'h000) begin
         good = 1'h1;
      end else if ((inc || dec) && hold == 0) begin
         mptr = inc ? ((mptr == 10'h30E) ? 10'h000 : mptr + 10'h001)
                    : ((mptr == 10'h000) ? 10'h30E : mptr - 10'h001);
         good = 1'h1;
         op = 1'h1;
      end else if (ndf && mst != 2'h1) begin
         mst = 2'h0;
         mptr = v;
         good = (old == 2'h0);
         op = 1'h1;
      end
      if (run >= 3) begin
         mst = 2'h0;
         mptr = v;
      end
      if (ais >= 3) mst = 2'h2;
      if (p == 16'hFFFF && old == 2'h2) good = 1'h1;
      bad = (old == 2'h1 || good) ? 0 : bad + 1;
      if (bad >= 8 && mst == old && run != 3) begin
         mst = 2'h1;
         bad = 0;
      end
      hold = op ? 3 : ((hold > 0) ? hold - 1 : 0);
      if ((old == 2'h2) != (mst == 2'h2)) mstat = mstat | 4'h5;
      if ((old == 2'h1) != (mst == 2'h1)) mstat = mstat | 4'hA;
   endtask : model
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   function automatic logic [15:0] pw(input logic [9:0] m);
      return {4'h6, mctrl[0] ? 2'h2 : 2'h0, mptr ^ m};
   endfunction : pw
   task automatic frame(input logic [15:0] p);
      tx.send(p, 2, (p == 16'hFFFF) ? p : {4'h9, mctrl[0] ? 2'h2 : 2'h0, 10'h3FF});
      model(p);
      repeat (2) @(posedge clk_i);
      check("irq_first", {31'h0, irq_a}, {31'h0, mstat[2] & mctrl[1] | mstat[3] & mctrl[3]});
      check("irq_second", {31'h0, irq_b}, {31'h0, mstat[2] & mctrl[2] | mstat[3] & mctrl[4]});
      bus(1'h0, 4'h8, 4'hF, 32'h0);
      check("pointer", rd, {22'h0, mptr});
      bus(1'h0, 4'h4, 4'hF, 32'h0);
      check("status", rd, {26'h0, mst, mstat});
      mstat = {2'h0, mst == 2'h1, mst == 2'h2};
   endtask : frame
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      bus(1'h1, 4'h0, 4'hE, 32'h1F);
      bus(1'h0, 4'h0, 4'hF, 32'h0);
      check("ctrl", rd, 32'h0);
      bus(1'h1, 4'hC, 4'hF, 32'h1F);
      bus(1'h0, 4'hC, 4'hF, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'h1, 4'h0, 4'hF, 32'h12);
      mctrl = 5'h12;
      repeat (3) frame(16'h620A);
      frame(pw(10'h2AA));
      frame(pw(10'h155));
      repeat (2) frame(pw(10'h000));
      frame(pw(10'h155));
      frame(16'hB30E);
      repeat (3) frame(pw(10'h000));
      frame(pw(10'h2AA));
      repeat (3) frame(pw(10'h000));
      frame(pw(10'h155));
      repeat (8) frame(16'h0000);
      repeat (3) frame(16'hFFFF);
      frame(16'h9100);
      bus(1'h1, 4'h0, 4'hF, 32'h0D);
      mctrl = 5'h0D;
      frame(pw(10'h000) & 16'hF7FF);
      repeat (3) frame(pw(10'h000));
      frame(pw(10'h2A0));
      repeat (3) frame(pw(10'h000));
      frame(pw(10'h3F0));
      frame(pw(10'h150));
      bus(1'h1, 4'h0, 4'hF, 32'h16);
      mctrl = 5'h16;
      for (int i = 0; i < 40; i++) begin
         lfsr = lfsr_next(lfsr);
         case (lfsr[1:0])
            2'h0: frame(pw(10'h000));
            2'h1: frame(pw(10'h2AA ^ {6'h00, lfsr[5:2]}));
            2'h2: frame(pw(10'h155 ^ {6'h00, lfsr[5:2]}));
            default: frame(16'hFFFF);
         endcase
      end
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      test_done();
   end
endmodule : tb
`default_nettype wire
